// File: pkg/rbg_map.vh
`ifndef RBG_MAP_VH
`define RBG_MAP_VH

// State chain and output word geometry.
`define RBG_STATE_COUNT   8
`define RBG_STATE_W       3
`define RBG_WORD_W        8
`define RBG_MSB_SEL       3'h7
`define RBG_STATE_FIRST   3'h1
`define RBG_STATE_RESET   3'h0

// Pattern length: the loaded value plus one bits, up to 64.
`define RBG_LEN_W         6
`define RBG_LEN_RESET     6'h3f

// Serial clock timing; the core clock period is 10 ns.
`define RBG_CLK_PERIOD_NS 10
`define RBG_HALF_BIT_NS   40
`define RBG_HALF_CYCLES   ((`RBG_HALF_BIT_NS + `RBG_CLK_PERIOD_NS - 1) / `RBG_CLK_PERIOD_NS)
`define RBG_HALF_CNT_W    4
// Last count of one serial clock half, one less than the cycle count above.
`define RBG_HALF_LAST     4'h3

`endif

// File: design/rbg_out_buffer.v
// Two-entry buffer between the bit generator and the serial output stage.
module rbg_out_buffer #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input  wire             core_clk,
  input  wire             reset,
  // Filling side.
  input  wire [WIDTH-1:0] inData,
  input  wire             inValid,
  output wire             inReady,
  // Draining side.
  output wire [WIDTH-1:0] outData,
  output wire             outValid,
  input  wire             outReady
);

  reg [WIDTH-1:0] slot0_reg;
  reg [WIDTH-1:0] slot1_reg;
  reg [1:0]       count_reg;

  wire pushFire;
  wire popFire;

  // Full and empty come straight from the occupancy count.
  assign inReady  = (count_reg != 2'h2);
  assign outValid = (count_reg != 2'h0);
  assign outData  = slot0_reg;
  assign pushFire = inValid && inReady;
  assign popFire  = outValid && outReady;

  // Slot 0 is always the head; a pop shifts slot 1 forward.
  always @(posedge core_clk) begin
    if (reset) begin
      count_reg <= 2'h0;
      slot0_reg <= {WIDTH{1'b0}};
      slot1_reg <= {WIDTH{1'b0}};
    end else begin
      case ({pushFire, popFire})
        2'b10: begin
          if (count_reg == 2'h0) begin
            slot0_reg <= inData;
          end else begin
            slot1_reg <= inData;
          end
          count_reg <= count_reg + 2'h1;
        end
        2'b01: begin
          slot0_reg <= slot1_reg;
          count_reg <= count_reg - 2'h1;
        end
        2'b11: begin
          if (count_reg == 2'h1) begin
            slot0_reg <= inData;
          end else begin
            slot0_reg <= slot1_reg;
            slot1_reg <= inData;
          end
        end
        default: begin
          count_reg <= count_reg;
        end
      endcase
    end
  end

endmodule // rbg_out_buffer

// File: design/rbg_bitstream.v
`include "rbg_map.vh"

module rbg_bitstream (
  // Clock and reset.
  input  wire       core_clk,
  input  wire       reset,
  // Pins from outside the clock domain.
  input  wire       startIn,
  input  wire       enableIn,
  input  wire       rxReady,
  // Host update port from the serial configuration slave, same clock.
  input  wire       lengthWrite,
  input  wire [5:0] lengthValue,
  input  wire       memWrite,
  input  wire [2:0] memAddr,
  input  wire [7:0] memData,
  // Serial link to the receiver.
  output reg        serClk,
  output reg        serData,
  // Status.
  output reg  [2:0] stateOut,
  output reg        stepClk
);

  // Output stage states: resting between bits, then the low half and the
  // high half of one serial clock period.
  localparam OS_IDLE = 2'h0;
  localparam OS_LOW  = 2'h1;
  localparam OS_HIGH = 2'h2;

  // Per-state words, input synchronisers and the stepping machinery.
  reg [`RBG_WORD_W-1:0]     patMem [0:`RBG_STATE_COUNT-1];
  reg [1:0]                 startSync_reg;
  reg [1:0]                 enableSync_reg;
  reg [1:0]                 readySync_reg;
  reg                       running_reg;
  reg [`RBG_STATE_W-1:0]    state_reg;
  reg [`RBG_STATE_W-1:0]    state_next;
  reg [`RBG_STATE_W-1:0]    bitSel_reg;
  reg [`RBG_LEN_W-1:0]      length_reg;
  reg [`RBG_LEN_W-1:0]      bitsSent_reg;
  reg [1:0]                 os_reg;
  reg [`RBG_HALF_CNT_W-1:0] halfCnt_reg;
  reg                       restart;
  integer                   i;

  // Internal nets between the generator, the buffer and the output stage.
  wire                       startSync;
  wire                       enableSync;
  wire                       readySync;
  wire                       muxBit;
  wire                       genValid;
  wire                       genReady;
  wire                       bufBit;
  wire                       bufValid;
  wire                       popReady;
  wire                       pushFire;
  wire                       stepEdge;
  wire [`RBG_STATE_COUNT-1:0] condRaw;
  wire [`RBG_STATE_COUNT-1:0] cond;
  wire [`RBG_HALF_CNT_W-1:0] halfLast;

  // Eight-way selection of one bit of a stored word. The select comes from
  // the generator, so the stored word itself never has to shift.
  function sel8;
    input [7:0] word;
    input [2:0] sel;
    begin
      sel8 = word[sel];
    end
  endfunction

  // Position of the single raised transition condition. The guard leaves
  // at most one bit high, so the empty case simply reports zero.
  function [2:0] condIndex;
    input [7:0] c;
    integer k;
    begin
      condIndex = 3'h0;
      for (k = 0; k < 8; k = k + 1) begin
        if (c[k]) begin
          condIndex = k[2:0];
        end
      end
    end
  endfunction

  // Outside levels pass two flops before any logic reads them.
  // Only the second flop is read, so a metastable first stage never leaks.
  always @(posedge core_clk) begin
    if (reset) begin
      startSync_reg  <= 2'h0;
      enableSync_reg <= 2'h0;
      readySync_reg  <= 2'h0;
    end else begin
      startSync_reg  <= {startSync_reg[0], startIn};
      enableSync_reg <= {enableSync_reg[0], enableIn};
      readySync_reg  <= {readySync_reg[0], rxReady};
    end
  end

  // Synchronised levels and the last count of each serial clock half.
  assign startSync  = startSync_reg[1];
  assign enableSync = enableSync_reg[1];
  assign readySync  = readySync_reg[1];
  assign halfLast   = `RBG_HALF_LAST;

  // Per-state output memory; reset loads the 3-bit counter pattern.
  // A host write takes effect on the next bit drawn from that word.
  always @(posedge core_clk) begin
    if (reset) begin
      for (i = 0; i < `RBG_STATE_COUNT; i = i + 1) begin
        patMem[i] <= i[7:0];
      end
    end else if (memWrite) begin
      patMem[memAddr] <= memData;
    end
  end

  // Length counter data, rewritable by the host at any time.
  // Limitation: a new value below the bits already sent lets the count run
  // on and wrap, so the new length can take up to one extra pass to apply.
  always @(posedge core_clk) begin
    if (reset) begin
      length_reg <= `RBG_LEN_RESET;
    end else if (lengthWrite) begin
      length_reg <= lengthValue;
    end
  end

  // The generator offers a bit only while started and enabled; a full
  // buffer stalls it, so a slow receiver never loses a bit. State 0 is
  // part of the loop once running, so its word is sent after state 7.
  assign muxBit   = sel8(patMem[state_reg], bitSel_reg);
  assign genValid = running_reg && enableSync;
  assign pushFire = genValid && genReady;

  // At lengths above 8 the stepping clock toggles once the last bit of a word is taken, so a
  // pulse lasts one word time, or less when a restart cuts a word short, far longer than one transition.
  assign stepEdge = pushFire && (bitSel_reg == 3'h0);

  // Raw conditions: only the current state may see the stepping edge.
  // Each condition only ever points at its own successor in the chain.
  genvar g;
  generate
    for (g = 0; g < `RBG_STATE_COUNT; g = g + 1) begin : gCond
      assign condRaw[g] = stepEdge && (state_reg == g);
      // A condition is masked while its lower neighbour is also high.
      if (g == 0) begin : gFirst
        assign cond[g] = condRaw[g] && !condRaw[`RBG_STATE_COUNT-1];
      end else begin : gRest
        assign cond[g] = condRaw[g] && !condRaw[g-1];
      end
    end
  endgenerate

  // Next state along the series chain; a restart takes priority.
  // Before start the machine is pinned to state 0 whatever else happens.
  always @* begin
    restart    = pushFire && (bitsSent_reg == length_reg);
    state_next = state_reg;
    if (!running_reg) begin
      state_next = `RBG_STATE_RESET;
      if (startSync) begin
        state_next = `RBG_STATE_FIRST;
      end
    end else if (restart) begin
      state_next = `RBG_STATE_FIRST;
    end else if (|cond) begin
      state_next = condIndex(cond) + 3'h1;
    end
  end

  // Clocked state machine, bit select and bit counter.
  always @(posedge core_clk) begin
    if (reset) begin
      running_reg  <= 1'b0;
      state_reg    <= `RBG_STATE_RESET;
      bitSel_reg   <= `RBG_MSB_SEL;
      bitsSent_reg <= {`RBG_LEN_W{1'b0}};
    end else begin
      state_reg <= state_next;
      if (!running_reg && startSync) begin
        running_reg <= 1'b1;
      end
      if (pushFire) begin
        if (restart) begin
          bitSel_reg   <= `RBG_MSB_SEL;
          bitsSent_reg <= {`RBG_LEN_W{1'b0}};
        end else begin
          bitSel_reg   <= bitSel_reg - 3'h1;
          bitsSent_reg <= bitsSent_reg + 6'h01;
        end
      end
    end
  end

  // Stepping clock: it toggles exactly when the state moves, on start, on
  // each word boundary and on a restart from another state. A restart that
  // stays in state 1 leaves it alone, so no toggle goes by without a step.
  always @(posedge core_clk) begin
    if (reset) begin
      stepClk <= 1'b0;
    end else if (state_next != state_reg) begin
      stepClk <= ~stepClk;
    end
  end

  // The buffer holds selected bits until the output stage shifts them.
  // Two slots let the generator run two bits ahead of the link.
  rbg_out_buffer #(
    .WIDTH (1)
  ) uBuffer (
    .core_clk (core_clk),
    .reset    (reset),
    .inData   (muxBit),
    .inValid  (genValid),
    .inReady  (genReady),
    .outData  (bufBit),
    .outValid (bufValid),
    .outReady (popReady)
  );

  // A bit is taken only when the stage is idle and the receiver is ready.
  // Ready is a pin, so it is read only through its synchroniser.
  assign popReady = (os_reg == OS_IDLE) && enableSync && readySync;

  // Output stage: data is set up while the clock is low, and the
  // receiver samples on the rising edge. Disabled, the clock rests low.
  always @(posedge core_clk) begin
    if (reset) begin
      os_reg      <= OS_IDLE;
      halfCnt_reg <= {`RBG_HALF_CNT_W{1'b0}};
      serClk      <= 1'b0;
      serData     <= 1'b0;
    end else begin
      case (os_reg)
        // Between bits: take the next bit, or track the top bit when disabled.
        OS_IDLE: begin
          serClk <= 1'b0;
          if (bufValid && popReady) begin
            serData     <= bufBit;
            halfCnt_reg <= {`RBG_HALF_CNT_W{1'b0}};
            os_reg      <= OS_LOW;
          end else if (!enableSync) begin
            serData <= patMem[state_reg][`RBG_WORD_W-1];
          end
        end
        // Low half: data is set up a full half period before the rise.
        OS_LOW: begin
          if (halfCnt_reg == halfLast) begin
            halfCnt_reg <= {`RBG_HALF_CNT_W{1'b0}};
            serClk      <= 1'b1;
            os_reg      <= OS_HIGH;
          end else begin
            halfCnt_reg <= halfCnt_reg + 4'h1;
          end
        end
        // High half: data holds while the receiver samples it.
        OS_HIGH: begin
          if (halfCnt_reg == halfLast) begin
            halfCnt_reg <= {`RBG_HALF_CNT_W{1'b0}};
            serClk      <= 1'b0;
            os_reg      <= OS_IDLE;
          end else begin
            halfCnt_reg <= halfCnt_reg + 4'h1;
          end
        end
        default: begin
          os_reg <= OS_IDLE;
          serClk <= 1'b0;
        end
      endcase
    end
  end

  // Current state is shown for observation by the host.
  // It lags the internal state and stepClk by one cycle.
  always @(posedge core_clk) begin
    if (reset) begin
      stateOut <= `RBG_STATE_RESET;
    end else begin
      stateOut <= state_reg;
    end
  end

endmodule // rbg_bitstream

// File: testbench/rbg_bitstream_props.sv
module rbg_bitstream_props (
  // Clock and reset.
  input wire       core_clk,
  input wire       reset,
  // Watched ports.
  input wire       enableIn,
  input wire       serClk,
  input wire       serData,
  input wire [2:0] stateOut,
  input wire       stepClk
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // One serial clock pulse is four cycles high.
  sequence clkPulse;
    serClk [*4] ##1 !serClk;
  endsequence
  // Long enough low for the clock of a bit launched before the disable to have risen.
  sequence offLong;
    (!enableIn) [*8];
  endsequence
  AST_CLK_EN:
  assert property (offLong |=> !$rose(serClk)) else $error("clock rose while disabled");
  AST_CLK_HIGH:
  assert property ($rose(serClk) |-> clkPulse) else $error("bad clock pulse width");
  AST_GAP:
  assert property ($fell(serClk) |-> (!serClk) [*5]) else $error("bit period too short");
  AST_DATA_HOLD:
  assert property (serClk && $past(serClk) |-> $stable(serData)) else $error("data moved");
  AST_CHAIN:
  assert property ($changed(stateOut) |-> stateOut == $past(stateOut) + 3'h1
    || stateOut == 3'h1) else $error("state skipped");
  AST_STEP_CAUSE:
  assert property ($changed(stateOut) |-> $past(stepClk) != $past(stepClk, 2))
    else $error("state moved without step");
  AST_STEP_ONE:
  assert property ($changed(stepClk) |=> $stable(stepClk) [*2]) else $error("double step");
  AST_RESET:
  assert property (disable iff (1'b0) reset |=> !serClk && !stepClk && stateOut == 3'h0)
    else $error("reset values wrong");
endmodule // rbg_bitstream_props

// File: testbench/rbg_rx_model.sv
module rbg_rx_model (
  // Clocks.
  input wire core_clk,
  input wire rxClk,
  // Link from the block.
  input wire serClk,
  input wire serData,
  // Stall control.
  input wire stallEn,
  output reg rxReady
);
  timeunit 1ns;
  timeprecision 1ns;
  bit got[$];
  reg lastClk = 1'b0;
  int seed    = 32'h39f9;
  initial rxReady = 1'b1;
  // Ready moves on the slow receiver clock, so stalls hit any phase of a bit.
  always @(negedge rxClk) begin
    rxReady <= !stallEn || (($random(seed) & 1) != 0);
  end
  // A bit is taken at each rising serial clock.
  always @(posedge core_clk) begin
    lastClk <= serClk;
    if (serClk && !lastClk) got.push_back(serData);
  end
endmodule // rbg_rx_model

// File: testbench/rbg_bitstream_tb.sv
bind rbg_bitstream rbg_bitstream_props chk (.core_clk(core_clk), .reset(reset),
  .enableIn(enableIn), .serClk(serClk), .serData(serData), .stateOut(stateOut),
  .stepClk(stepClk));
module rbg_bitstream_tb;
  timeunit 1ns;
  timeprecision 1ns;
  reg       core_clk = 0, reset = 1, startIn = 0, enableIn = 0, rxClk = 0, stallEn = 0;
  reg       lengthWrite = 0, memWrite = 0;
  reg [5:0] lengthValue = 0;
  reg [2:0] memAddr = 0;
  reg [7:0] memData = 0;
  wire      serClk, serData, stepClk, rxReady;
  wire [2:0] stateOut;
  int       fail_count = 0, num_checks = 0, seed = 32'h39f9;
  int       mem[8];
  initial forever #5 core_clk = ~core_clk;
  initial forever #80 rxClk = ~rxClk;
  rbg_bitstream uut (.core_clk(core_clk), .reset(reset), .startIn(startIn),
    .enableIn(enableIn), .rxReady(rxReady), .lengthWrite(lengthWrite),
    .lengthValue(lengthValue), .memWrite(memWrite), .memAddr(memAddr), .memData(memData),
    .serClk(serClk), .serData(serData), .stateOut(stateOut), .stepClk(stepClk));
  rbg_rx_model rx (.core_clk(core_clk), .rxClk(rxClk), .serClk(serClk),
    .serData(serData), .stallEn(stallEn), .rxReady(rxReady));
  // Compares one value and counts it.
  task check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task clk(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Resets, loads the pattern, starts it and compares the first nbits bits with the model.
  task run(input int l, input bit rnd, input bit stall, input int nbits);
    int i, idx;
    reset = 1;
    clk(6);
    reset = 0;
    startIn = 0;
    stallEn = stall;
    rx.got.delete();
    for (i = 0; i < 8; i++) mem[i] = i;
    for (i = 0; i < 8 && rnd; i++) begin
      mem[i] = $random(seed) & 8'hff;
      memWrite = 1;
      memAddr = i;
      memData = mem[i];
      clk(1);
    end
    memWrite = 0;
    // The longest pattern relies on the reset length, so no write is made for it.
    lengthWrite = (l != 63);
    lengthValue = l;
    clk(1);
    lengthWrite = 0;
    clk(10);
    check(stateOut, 0);
    check(serData, mem[0] >> 7);
    startIn = 1;
    clk(6);
    check(stateOut, 1);
    enableIn = 1;
    for (i = 0; i < 20000 && rx.got.size() < nbits; i++) clk(1);
    enableIn = 0;
    check(rx.got.size() >= nbits, 1);
    for (i = 0; i < nbits; i++) begin
      idx = i % (l + 1);
      check(rx.got[i], mem[(1 + idx / 8) % 8] >> (7 - idx % 8) & 1);
    end
    clk(20);
    check(serData, mem[stateOut] >> 7 & 1);
    $display("test done length %0d", l + 1);
  endtask
  // Counter words at full length, then host words at short lengths, with stalls except at length 1.
  initial begin
    run(63, 0, 0, 130);
    run(12, 1, 1, 40);
    run(0, 1, 0, 5);
    run(15, 1, 1, 40);
    stop_test;
  end
  initial begin
    #400us;
    fail_count++;
    stop_test;
  end
endmodule // rbg_bitstream_tb
